// ==== logic/pus_pkg.sv ====
/*
  Constants, timing counts and carrier types for the power-up reset sequencer.
  Assumes the sequencer clock is the oscillator clock at 25 MHz.
*/
package pus_pkg;
  localparam int CLK_PERIOD_NS = 40;

  // power-up phases, in oscillator cycles
  localparam logic [11:0] PH_OSC_CYC = 12'h408;
  localparam logic [11:0] PH_FUSE_CYC = 12'h488;
  localparam logic [11:0] PH_PUMP_CYC = 12'h2B0;
  localparam logic [11:0] PH_BANK_CYC = 12'h269;

  // pin glitch filters: shortest accepted low pulse, rounded up
  localparam int PIN_FILT_MIN_NS = 475;
  localparam int PIN_FILT_MAX_NS = 2000;
  localparam int PIN_FILT_CYC = (PIN_FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // supply glitch filter: widest glitch swallowed, plus one cycle
  localparam int SUP_GLITCH_MAX_NS = 1000;
  localparam int SUP_FILT_CYC = SUP_GLITCH_MAX_NS / CLK_PERIOD_NS + 1;

  // warm reset pin hold times
  localparam logic [11:0] WARM_POR_HOLD_CYC = 12'h8D0;
  localparam logic [11:0] WARM_OTHER_HOLD_CYC = 12'h020;

  localparam logic [31:0] BOOT_ADDR = 32'h00000000;
  localparam int NUM_DOMAINS = 4;

  // exception status bit positions
  localparam int EXC_POWER_UP = 15;
  localparam int EXC_WATCHDOG = 13;
  localparam int EXC_SELF_TEST = 5;
  localparam int EXC_SOFTWARE = 4;
  localparam int EXC_EXTERNAL = 3;
  // global status bit positions
  localparam int GLB_OSC_FAIL = 0;
  localparam int GLB_PLL_SLIP0 = 8;
  localparam int GLB_PLL_SLIP1 = 9;

  typedef enum logic [2:0] {
    ST_POR, ST_OSC, ST_FUSE, ST_PUMP, ST_BANK, ST_RUN
  } pus_state_t;

  // one-cycle reset-cause event pulses from the rest of the chip
  typedef struct packed {
    logic osc_fail;
    logic [1:0] pll_slip;
    logic watchdog;
    logic self_test;
    logic software;
  } pus_cause_t;
endpackage

// ==== logic/pus_glitch_filt.sv ====
/*
  Level glitch filter: output follows the input only after the input has
  held its new level for CYC consecutive clocks.
  Assumes input is synchronous to ref_clk.
*/
`timescale 1ns/1ps
module pus_glitch_filt #(
  parameter int CYC = 12,
  parameter logic INIT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic lvl_in,
  output logic lvl_out_r
);
  logic [7:0] cnt_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
      lvl_out_r <= INIT;
    end else if (lvl_in == lvl_out_r) begin
      cnt_r <= 8'h00;
    end else if (cnt_r == 8'(CYC - 1)) begin
      cnt_r <= 8'h00;
      lvl_out_r <= lvl_in;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule // pus_glitch_filt

// ==== logic/pus_sequencer.sv ====
/*
  Power-up and reset sequencer: supply monitor, reset pin filters, phased
  power-up, open-drain warm reset pin, reset cause flags, domain switching.
  Assumes all inputs synchronous to ref_clk (oscillator clock); the
  peripheral clock is taken equal to ref_clk for the warm reset hold.
*/
`timescale 1ns/1ps
module pus_sequencer (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic core_supply_ok,
  input wire logic core_supply_not_high,
  input wire logic io_supply_ok,
  input wire logic low_power_mode,
  input wire logic power_on_reset_n,
  input wire logic warm_reset_n_in,
  input wire pus_pkg::pus_cause_t cause_evt,
  input wire logic [15:0] exc_status_clr,
  input wire logic [9:0] glb_status_clr,
  input wire logic [pus_pkg::NUM_DOMAINS-1:0] domain_on_req,
  output logic core_power_good_r,
  output logic io_power_good_r,
  output logic pins_hiz_r,
  output logic warm_reset_out_r,
  output logic warm_reset_oe_r,
  output logic cpu_reset_n_r,
  output logic [31:0] boot_addr_r,
  output pus_pkg::pus_state_t phase_r,
  output logic [15:0] exc_status_r,
  output logic [9:0] glb_status_r,
  output logic always_on_domain_r,
  output logic [pus_pkg::NUM_DOMAINS-1:0] domain_on_r
);
  import pus_pkg::*;

  function automatic logic [11:0] ph_len(input pus_state_t s);
    case (s)
      ST_OSC: ph_len = PH_OSC_CYC - 12'd1;
      ST_FUSE: ph_len = PH_FUSE_CYC - 12'd1;
      ST_PUMP: ph_len = PH_PUMP_CYC - 12'd1;
      ST_BANK: ph_len = PH_BANK_CYC - 12'd1;
      default: ph_len = 12'd0;
    endcase
  endfunction

  logic io_ok_f, core_ok_f, core_hi_ok_f, por_pin_f, warm_pin_f;
  logic mon_io_low, mon_core_bad, por_int;
  logic por_s1_r, por_s2_r;
  pus_state_t st_r;
  logic [11:0] cnt_r, hold_r, hold_nxt;
  logic own_drive_r, ext_evt, int_evt, por_rel;
  logic [NUM_DOMAINS-1:0] domain_done_r;

  pus_glitch_filt #(.CYC(SUP_FILT_CYC), .INIT(1'b0)) u_io_filt (
    .ref_clk(ref_clk), .rst_b(rst_b), .lvl_in(io_supply_ok), .lvl_out_r(io_ok_f));
  pus_glitch_filt #(.CYC(SUP_FILT_CYC), .INIT(1'b0)) u_core_filt (
    .ref_clk(ref_clk), .rst_b(rst_b), .lvl_in(core_supply_ok), .lvl_out_r(core_ok_f));
  pus_glitch_filt #(.CYC(SUP_FILT_CYC), .INIT(1'b1)) u_corehi_filt (
    .ref_clk(ref_clk), .rst_b(rst_b), .lvl_in(core_supply_not_high),
    .lvl_out_r(core_hi_ok_f));
  pus_glitch_filt #(.CYC(PIN_FILT_CYC), .INIT(1'b0)) u_por_filt (
    .ref_clk(ref_clk), .rst_b(rst_b), .lvl_in(power_on_reset_n), .lvl_out_r(por_pin_f));
  pus_glitch_filt #(.CYC(PIN_FILT_CYC), .INIT(1'b0)) u_warm_filt (
    .ref_clk(ref_clk), .rst_b(rst_b), .lvl_in(warm_reset_n_in), .lvl_out_r(warm_pin_f));

  // monitor contributions vanish in low power mode
  assign mon_io_low = !io_ok_f && !low_power_mode;
  assign mon_core_bad = !(core_ok_f && core_hi_ok_f) && !low_power_mode;
  // no supply ordering: any one holds the sequence back
  assign por_int = !por_pin_f || mon_io_low || mon_core_bad;

  // deassertion synchronised, assertion seen two clocks later
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      por_s1_r <= 1'b1;
      por_s2_r <= 1'b1;
    end else begin
      por_s1_r <= por_int;
      por_s2_r <= por_s1_r;
    end
  end

  assign por_rel = (st_r == ST_POR) && !por_s2_r;

  // both power-goods follow the weaker supply
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_power_good_r <= 1'b0;
      io_power_good_r <= 1'b0;
    end else begin
      core_power_good_r <= io_ok_f && core_ok_f;
      io_power_good_r <= io_ok_f && core_ok_f;
    end
  end

  // one clock behind the filtered fault; outputs keep going high-z
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pins_hiz_r <= 1'b1;
    end else begin
      pins_hiz_r <= mon_core_bad;
    end
  end

  // phase sequencer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_POR;
      cnt_r <= 12'd0;
    end else if (por_s2_r) begin
      st_r <= ST_POR;
      cnt_r <= 12'd0;
    end else begin
      case (st_r)
        ST_POR: begin
          st_r <= ST_OSC;
          cnt_r <= ph_len(ST_OSC);
        end
        ST_OSC: begin
          if (cnt_r == 12'd0) begin
            st_r <= ST_FUSE;
            cnt_r <= ph_len(ST_FUSE);
          end else begin
            cnt_r <= cnt_r - 12'd1;
          end
        end
        ST_FUSE: begin
          if (cnt_r == 12'd0) begin
            st_r <= ST_PUMP;
            cnt_r <= ph_len(ST_PUMP);
          end else begin
            cnt_r <= cnt_r - 12'd1;
          end
        end
        ST_PUMP: begin
          if (cnt_r == 12'd0) begin
            st_r <= ST_BANK;
            cnt_r <= ph_len(ST_BANK);
          end else begin
            cnt_r <= cnt_r - 12'd1;
          end
        end
        ST_BANK: begin
          if (cnt_r == 12'd0) begin
            st_r <= ST_RUN;
          end else begin
            cnt_r <= cnt_r - 12'd1;
          end
        end
        ST_RUN: cnt_r <= 12'd0;
        default: begin
          st_r <= ST_POR;
          cnt_r <= 12'd0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= ST_POR;
    end else begin
      phase_r <= st_r;
    end
  end

  // our own drive reads back low; ignore the pin until it is seen high again
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      own_drive_r <= 1'b1;
    end else if (warm_reset_oe_r) begin
      own_drive_r <= 1'b1;
    end else if (warm_pin_f) begin
      own_drive_r <= 1'b0;
    end
  end

  assign ext_evt = !warm_pin_f && !own_drive_r && !warm_reset_oe_r;
  assign int_evt = cause_evt.osc_fail || (|cause_evt.pll_slip) || cause_evt.watchdog ||
                   cause_evt.self_test || cause_evt.software;

  // warm reset hold counter
  always_comb begin
    hold_nxt = hold_r;
    if (st_r == ST_POR) begin
      hold_nxt = WARM_POR_HOLD_CYC;
    end else if (hold_r != 12'd0) begin
      hold_nxt = hold_r - 12'd1;
    end
    if ((int_evt || ext_evt) && hold_nxt < WARM_OTHER_HOLD_CYC) begin
      hold_nxt = WARM_OTHER_HOLD_CYC;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_r <= WARM_POR_HOLD_CYC;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // open drain: the data is always low, only the enable moves
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      warm_reset_out_r <= 1'b0;
      warm_reset_oe_r <= 1'b1;
    end else begin
      warm_reset_out_r <= 1'b0;
      warm_reset_oe_r <= (hold_nxt != 12'd0) || (st_r != ST_RUN) || por_s2_r;
    end
  end

  // held while the pin is low for any reason, external included
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_reset_n_r <= 1'b0;
      boot_addr_r <= BOOT_ADDR;
    end else begin
      cpu_reset_n_r <= (st_r == ST_RUN) && !por_s2_r && (hold_nxt == 12'd0) &&
                       warm_pin_f && !ext_evt;
      boot_addr_r <= BOOT_ADDR;
    end
  end

  // cause flags: a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      exc_status_r <= 16'h8000;
    end else begin
      exc_status_r <= exc_status_r & ~exc_status_clr;
      if (st_r == ST_POR) begin
        exc_status_r[EXC_POWER_UP] <= 1'b1;
      end
      if (cause_evt.watchdog) begin
        exc_status_r[EXC_WATCHDOG] <= 1'b1;
      end
      if (cause_evt.self_test) begin
        exc_status_r[EXC_SELF_TEST] <= 1'b1;
      end
      if (cause_evt.software) begin
        exc_status_r[EXC_SOFTWARE] <= 1'b1;
      end
      if (ext_evt) begin
        exc_status_r[EXC_EXTERNAL] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      glb_status_r <= 10'h000;
    end else begin
      glb_status_r <= glb_status_r & ~glb_status_clr;
      if (cause_evt.osc_fail) begin
        glb_status_r[GLB_OSC_FAIL] <= 1'b1;
      end
      if (cause_evt.pll_slip[0]) begin
        glb_status_r[GLB_PLL_SLIP0] <= 1'b1;
      end
      if (cause_evt.pll_slip[1]) begin
        glb_status_r[GLB_PLL_SLIP1] <= 1'b1;
      end
    end
  end

  // domains switch only while the cpu is still in reset, once each;
  // clock gating ahead of switch-off is software's job
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      always_on_domain_r <= 1'b1;
      domain_on_r <= '1;
      domain_done_r <= '0;
    end else begin
      always_on_domain_r <= 1'b1;
      for (int i = 0; i < NUM_DOMAINS; i++) begin
        if (!cpu_reset_n_r && !domain_done_r[i] && domain_on_req[i] != domain_on_r[i]) begin
          domain_on_r[i] <= domain_on_req[i];
          domain_done_r[i] <= 1'b1;
        end
      end
    end
  end

  AST_DOMAIN_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(domain_done_r[0]) |-> $stable(domain_on_r[0]))
    else $error("domain switched twice");
  AST_PG_LOW: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(io_ok_f && core_ok_f) |=> !core_power_good_r && !io_power_good_r)
    else $error("power good high with a supply low");
  AST_IO_POR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mon_io_low |-> ##[1:3] st_r == ST_POR)
    else $error("io supply low without power-on reset");
  AST_CORE_HIZ: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mon_core_bad |=> pins_hiz_r)
    else $error("core fault without high impedance");
  AST_LPM: assert property (@(posedge ref_clk) disable iff (!rst_b)
    low_power_mode && por_pin_f |-> !por_int)
    else $error("monitor reset in low power mode");
  AST_SUP_GLITCH: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(io_ok_f) |-> !$past(io_supply_ok, 1) && !$past(io_supply_ok, SUP_FILT_CYC))
    else $error("short supply glitch passed");
  AST_OSC_TO_FUSE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_r == ST_OSC && cnt_r == 12'd0 && !por_s2_r) |=>
      (st_r == ST_FUSE && cnt_r == PH_FUSE_CYC - 12'd1))
    else $error("phase order or length wrong");
  AST_CPU_REL: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(cpu_reset_n_r) |-> $past(st_r) == ST_RUN && boot_addr_r == BOOT_ADDR)
    else $error("cpu released early");
  AST_POR_FILT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(por_pin_f) |-> !$past(power_on_reset_n, PIN_FILT_CYC))
    else $error("short power-on pulse passed");
  AST_WARM_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_r == ST_POR && !por_s2_r) |=> warm_reset_oe_r[*8])
    else $error("warm pin released too early");
  AST_HOLD_DRIVE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    hold_r != 12'd0 |-> warm_reset_oe_r && !warm_reset_out_r)
    else $error("warm pin not driven low during hold");
  AST_WDOG_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cause_evt.watchdog |=> exc_status_r[EXC_WATCHDOG])
    else $error("watchdog cause not flagged");
  AST_OSC_FAIL: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cause_evt.osc_fail |=> glb_status_r[GLB_OSC_FAIL] && warm_reset_oe_r && !cpu_reset_n_r)
    else $error("oscillator fail not handled");
endmodule // pus_sequencer

// ==== testbench/pus_board_model.sv ====
/*
  Board side of the sequencer: supply comparators, supervisor on the
  power-on pin, warm pin with pull-up and an external pusher.
  Assumes the bench commands ramps, dips and pulls at ref_clk edges.
*/
`timescale 1ns/1ps
module pus_board_model #(
  parameter int HOLD_CYC = 25000
) (
  input wire logic ref_clk,
  input wire logic supply_up,
  input wire logic io_dip,
  input wire logic core_over,
  input wire logic por_req,
  input wire logic ext_pull,
  input wire logic dev_oe,
  input wire logic dev_out,
  output logic core_supply_ok,
  output logic core_supply_not_high,
  output logic io_supply_ok,
  output logic power_on_reset_n,
  output logic warm_reset_n
);
  int hold_cnt = 0;
  assign core_supply_ok = supply_up;
  assign core_supply_not_high = !core_over;
  assign io_supply_ok = supply_up & !io_dip;
  // 1 ms of ref_clk after the ramp before letting go
  always @(posedge ref_clk) begin
    if (!supply_up) begin
      hold_cnt <= 0;
    end else if (hold_cnt < HOLD_CYC) begin
      hold_cnt <= hold_cnt + 1;
    end
  end
  assign power_on_reset_n = (hold_cnt >= HOLD_CYC) & !por_req;
  // pull-up: released pin reads high, never a stale level
  assign warm_reset_n = !((dev_oe && !dev_out) || ext_pull);
endmodule // pus_board_model

// ==== testbench/pus_sequencer_test.sv ====
/*
  Self-checking bench for pus_sequencer: phases, pin filters, warm reset
  causes, status flags, supply dips and domain switching.
  Assumes pus_board_model stands for the supervisor and warm pin pull-up.
*/
`timescale 1ns/1ps
module pus_sequencer_test;
  import pus_pkg::*;
  logic ref_clk, rst_b, low_power_mode, warm_reset_n_in;
  logic supply_up, io_dip, core_over, por_req, ext_pull;
  logic core_supply_ok, core_supply_not_high, io_supply_ok, power_on_reset_n;
  pus_cause_t cause_evt, ev;
  logic [15:0] exc_status_clr, exc_status_r, exc_exp;
  logic [9:0] glb_status_clr, glb_status_r, glb_exp;
  logic [NUM_DOMAINS-1:0] domain_on_req, domain_on_r;
  logic core_power_good_r, io_power_good_r, pins_hiz_r, warm_reset_out_r;
  logic warm_reset_oe_r, cpu_reset_n_r, always_on_domain_r;
  logic [31:0] boot_addr_r;
  pus_state_t phase_r;
  pus_state_t last_ph = ST_POR;
  int err_count = 0;
  int num_checks = 0;
  int run = 0;
  int oe_cnt = 0;
  int last_oe = 0;
  int ph_len [8];

  pus_sequencer pus_sequencer_i (.ref_clk, .rst_b, .core_supply_ok, .core_supply_not_high,
    .io_supply_ok, .low_power_mode, .power_on_reset_n, .warm_reset_n_in, .cause_evt,
    .exc_status_clr, .glb_status_clr, .domain_on_req, .core_power_good_r, .io_power_good_r,
    .pins_hiz_r, .warm_reset_out_r, .warm_reset_oe_r, .cpu_reset_n_r, .boot_addr_r, .phase_r,
    .exc_status_r, .glb_status_r, .always_on_domain_r, .domain_on_r);

  pus_board_model pus_board_model_i (.ref_clk, .supply_up, .io_dip, .core_over, .por_req,
    .ext_pull, .dev_oe(warm_reset_oe_r), .dev_out(warm_reset_out_r), .core_supply_ok,
    .core_supply_not_high, .io_supply_ok, .power_on_reset_n, .warm_reset_n(warm_reset_n_in));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task close_out;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // phase lengths and order; warm pin drive length outside power-on
  always @(posedge ref_clk) begin
    if (phase_r !== last_ph) begin
      if (phase_r !== ST_POR) chk(phase_r, last_ph + 1);
      ph_len[last_ph] <= run;
      run <= 1;
      last_ph <= phase_r;
    end else begin
      run <= run + 1;
    end
    if (warm_reset_oe_r === 1'b1 && phase_r !== ST_POR) begin
      oe_cnt <= oe_cnt + 1;
    end else begin
      if (oe_cnt != 0) last_oe <= oe_cnt;
      oe_cnt <= 0;
    end
  end

  task set_line(input int which, input logic v);
    case (which)
      0: por_req <= v;
      1: ext_pull <= v;
      2: io_dip <= v;
      default: core_over <= v;
    endcase
  endtask

  // disturbance seen by the design for exactly n edges
  task pulse(input int which, input int n);
    @(posedge ref_clk);
    set_line(which, 1'b1);
    repeat (n) @(posedge ref_clk);
    set_line(which, 1'b0);
    @(negedge ref_clk);
  endtask

  task wait_cpu(input logic v, input int lim);
    int n;
    n = 0;
    while (cpu_reset_n_r !== v && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    if (cpu_reset_n_r !== v) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, cpu_reset_n_r, v);
      close_out;
    end else begin
      repeat (2) @(negedge ref_clk);
    end
  endtask

  task chk_phases;
    chk(ph_len[ST_OSC], PH_OSC_CYC);
    chk(ph_len[ST_FUSE], PH_FUSE_CYC);
    chk(ph_len[ST_PUMP], PH_PUMP_CYC);
    chk(ph_len[ST_BANK], PH_BANK_CYC);
    chk(last_oe >= WARM_POR_HOLD_CYC, 1);
    chk(phase_r, ST_RUN);
    chk(boot_addr_r, BOOT_ADDR);
    chk(exc_status_r[EXC_POWER_UP], 1);
  endtask

  initial begin
    rst_b = 1'b0;
    low_power_mode = 1'b0;
    supply_up = 1'b0;
    io_dip = 1'b0;
    core_over = 1'b0;
    por_req = 1'b0;
    ext_pull = 1'b0;
    cause_evt = '0;
    exc_status_clr = '0;
    glb_status_clr = '0;
    domain_on_req = 4'hA;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(exc_status_r, 16'h8000);
    chk(warm_reset_oe_r, 1);
    chk(always_on_domain_r, 1);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    supply_up <= 1'b1;
    repeat (20000) @(negedge ref_clk);
    chk(phase_r, ST_POR);
    // rest of the 1 ms hold, pin filter, sync and all four phases
    wait_cpu(1'b1, 9000);
    chk_phases;
    chk(domain_on_r, 4'hA);
    chk(warm_reset_out_r, 0);
    exc_exp = 16'h8000;
    glb_exp = '0;
    for (int i = 0; i < 5; i++) begin
      ev = '0;
      case (i)
        0: ev.watchdog = 1'b1;
        1: ev.self_test = 1'b1;
        2: ev.software = 1'b1;
        3: ev.osc_fail = 1'b1;
        default: ev.pll_slip = 2'h3;
      endcase
      exc_exp[EXC_WATCHDOG] |= ev.watchdog;
      exc_exp[EXC_SELF_TEST] |= ev.self_test;
      exc_exp[EXC_SOFTWARE] |= ev.software;
      glb_exp[GLB_OSC_FAIL] |= ev.osc_fail;
      glb_exp[GLB_PLL_SLIP1:GLB_PLL_SLIP0] |= ev.pll_slip;
      @(posedge ref_clk);
      cause_evt <= ev;
      @(posedge ref_clk);
      cause_evt <= '0;
      @(negedge ref_clk);
      chk(warm_reset_oe_r, 1);
      chk(cpu_reset_n_r, 0);
      wait_cpu(1'b1, 300);
      chk(last_oe >= WARM_OTHER_HOLD_CYC, 1);
      chk(exc_status_r, exc_exp);
      chk(glb_status_r, glb_exp);
    end
    @(posedge ref_clk);
    exc_status_clr <= '1;
    glb_status_clr <= '1;
    @(posedge ref_clk);
    exc_status_clr <= '0;
    glb_status_clr <= '0;
    @(negedge ref_clk);
    chk(exc_status_r, 16'h0000);
    chk(glb_status_r, 10'h000);
    pulse(1, 11);
    repeat (20) @(negedge ref_clk);
    chk(cpu_reset_n_r, 1);
    chk(exc_status_r[EXC_EXTERNAL], 0);
    pulse(1, 50);
    chk(exc_status_r[EXC_EXTERNAL], 1);
    chk(cpu_reset_n_r, 0);
    wait_cpu(1'b1, 300);
    pulse(0, 11);
    repeat (20) @(negedge ref_clk);
    chk(phase_r, ST_RUN);
    @(posedge ref_clk);
    // module clocks taken as already stopped by software before switch-off
    domain_on_req <= 4'h5;
    pulse(0, 50);
    chk(cpu_reset_n_r, 0);
    wait_cpu(1'b1, 4000);
    chk_phases;
    // bits 0 and 2 already used their one switch; bits 1 and 3 switch off now
    chk(domain_on_r, 4'h0);
    pulse(2, 20);
    chk(io_power_good_r, 1);
    pulse(2, 40);
    chk(core_power_good_r, 0);
    chk(io_power_good_r, 0);
    chk(cpu_reset_n_r, 0);
    wait_cpu(1'b1, 4000);
    chk_phases;
    pulse(3, 40);
    chk(pins_hiz_r, 1);
    chk(cpu_reset_n_r, 0);
    wait_cpu(1'b1, 4000);
    chk(pins_hiz_r, 0);
    @(posedge ref_clk);
    low_power_mode <= 1'b1;
    pulse(2, 40);
    repeat (10) @(negedge ref_clk);
    chk(cpu_reset_n_r, 1);
    chk(phase_r, ST_RUN);
    close_out;
  end
endmodule // pus_sequencer_test
